// >>> pkg/trdp_defs.vh
// Purpose: Shared constants for the test reset and debug port block
// Assumes: Included by bare name from every design file but the synchroniser
// Notes:   Offsets, codes and counts only; no logic
`ifndef TRDP_DEFS_VH
`define TRDP_DEFS_VH

// Test access state codes
`define TRDP_ST_RESET     4'h0
`define TRDP_ST_IDLE      4'h1
`define TRDP_ST_SEL_DR    4'h2
`define TRDP_ST_CAP_DR    4'h3
`define TRDP_ST_SH_DR     4'h4
`define TRDP_ST_EX1_DR    4'h5
`define TRDP_ST_PA_DR     4'h6
`define TRDP_ST_EX2_DR    4'h7
`define TRDP_ST_UPD_DR    4'h8
`define TRDP_ST_SEL_IR    4'h9
`define TRDP_ST_CAP_IR    4'hA
`define TRDP_ST_SH_IR     4'hB
`define TRDP_ST_EX1_IR    4'hC
`define TRDP_ST_PA_IR     4'hD
`define TRDP_ST_EX2_IR    4'hE
`define TRDP_ST_UPD_IR    4'hF

// Instruction register
`define TRDP_IR_W         4
`define TRDP_IR_CAPTURE   4'h1
`define TRDP_IR_BYPASS    4'hF
`define TRDP_IR_DEBUG     4'h8
`define TRDP_IR_RESET     4'hF

// Debug data register and commands
`define TRDP_DR_W         8
`define TRDP_CMD_ENTER    4'h1
`define TRDP_CMD_RESUME   4'h2
`define TRDP_CMD_TRIG     4'h3
`define TRDP_CMD_TRDEST   4'h4

// Trace destinations
`define TRDP_DEST_SERIAL  2'h0
`define TRDP_DEST_PAR     2'h1
`define TRDP_DEST_BUF     2'h2

// System reset qualification: four link clock periods of 200 ns at 25 ns
`define TRDP_SYSRST_NS    800
`define TRDP_CLK_NS       25
`define TRDP_SYSRST_CYC   ((`TRDP_SYSRST_NS + `TRDP_CLK_NS - 1) / `TRDP_CLK_NS)

// Link clock ceiling
`define TRDP_TCK_MAX_MHZ  25

`endif

// >>> src/trdp_sync.v
// Purpose: Two-stage synchroniser for a group of asynchronous levels
// Assumes: Destination clock is ref_clk_in
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module trdp_sync #(
    parameter WIDTH = 1
) (
    input  wire             ref_clk_in,
    input  wire             rst_n_in,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge ref_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    meta[i]     <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta[i]     <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule // trdp_sync

// >>> src/trdp_tap_fsm.v
// Purpose: Test access state machine advanced on sampled link clock rises
// Assumes: tck_rise_in is a one-cycle pulse per rising link clock edge
// Notes:   test_reset_in clears the state at once, ahead of any edge
`timescale 1ns/1ps
`include "trdp_defs.vh"
module trdp_tap_fsm (
    input  wire       ref_clk_in,
    input  wire       rst_n_in,
    input  wire       test_reset_in,
    input  wire       tck_rise_in,
    input  wire       tms_in,
    output reg  [3:0] state_out
);
    reg [3:0] next_state;

    always @* begin
        next_state = state_out;
        case (state_out)
            `TRDP_ST_RESET:  next_state = tms_in ? `TRDP_ST_RESET  : `TRDP_ST_IDLE;
            `TRDP_ST_IDLE:   next_state = tms_in ? `TRDP_ST_SEL_DR : `TRDP_ST_IDLE;
            `TRDP_ST_SEL_DR: next_state = tms_in ? `TRDP_ST_SEL_IR : `TRDP_ST_CAP_DR;
            `TRDP_ST_CAP_DR: next_state = tms_in ? `TRDP_ST_EX1_DR : `TRDP_ST_SH_DR;
            `TRDP_ST_SH_DR:  next_state = tms_in ? `TRDP_ST_EX1_DR : `TRDP_ST_SH_DR;
            `TRDP_ST_EX1_DR: next_state = tms_in ? `TRDP_ST_UPD_DR : `TRDP_ST_PA_DR;
            `TRDP_ST_PA_DR:  next_state = tms_in ? `TRDP_ST_EX2_DR : `TRDP_ST_PA_DR;
            `TRDP_ST_EX2_DR: next_state = tms_in ? `TRDP_ST_UPD_DR : `TRDP_ST_SH_DR;
            `TRDP_ST_UPD_DR: next_state = tms_in ? `TRDP_ST_SEL_DR : `TRDP_ST_IDLE;
            `TRDP_ST_SEL_IR: next_state = tms_in ? `TRDP_ST_RESET  : `TRDP_ST_CAP_IR;
            `TRDP_ST_CAP_IR: next_state = tms_in ? `TRDP_ST_EX1_IR : `TRDP_ST_SH_IR;
            `TRDP_ST_SH_IR:  next_state = tms_in ? `TRDP_ST_EX1_IR : `TRDP_ST_SH_IR;
            `TRDP_ST_EX1_IR: next_state = tms_in ? `TRDP_ST_UPD_IR : `TRDP_ST_PA_IR;
            `TRDP_ST_PA_IR:  next_state = tms_in ? `TRDP_ST_EX2_IR : `TRDP_ST_PA_IR;
            `TRDP_ST_EX2_IR: next_state = tms_in ? `TRDP_ST_UPD_IR : `TRDP_ST_SH_IR;
            `TRDP_ST_UPD_IR: next_state = tms_in ? `TRDP_ST_SEL_DR : `TRDP_ST_IDLE;
            default:         next_state = `TRDP_ST_RESET;
        endcase
    end

    // Any state reaches reset within five high samples, three from idle
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_out <= `TRDP_ST_RESET;
        end else if (test_reset_in) begin
            state_out <= `TRDP_ST_RESET;             // [R2]
        end else if (tck_rise_in) begin
            state_out <= next_state;                 // [R3] [R4] [R5]
        end
    end
endmodule // trdp_tap_fsm

// >>> src/trdp_port.v
// Behaviour
// R1 - Power-good never resets the test controller; only test reset or TMS.
// R2 - Test reset low clears the whole test subsystem and instruction register.
// R3 - Five high TMS samples on TCK rises force Test-Logic-Reset.
// R4 - Controller stays in Test-Logic-Reset while TMS samples high.
// R5 - After one stray low TMS, three high samples return to reset.
// R6 - In Test-Logic-Reset all test logic is off; normal operation continues.
// R7 - Straps are sampled and latched only on power-good assertion.
// R8 - Latched straps never change the shared pins' general bus functions.
// R9 - The four test pins are dedicated and never multiplexed.
// R10 - Basic debug works with TCK, TMS, TDI, TDO alone.
// R11 - TDO is high impedance whenever serial data is not driven.
// R12 - External unit holds system reset low at least four TCK periods.
// R13 - System reset low resets all system logic; may be ANDed with power-good.
// R14 - Break input requests debug entry, or toggles trace capture.
// R15 - Stop output is driven high on entry to debug mode.
// R16 - Optional trigger output from debug registers for a logic analyser.
// R17 - One test clock drives both the controller and the debug interface.
// R18 - Test logic works with a test clock up to 25 MHz; the code samples TCK at 40 MHz, which covers a 200 ns test clock.
// R19 - Trace goes to serial port, parallel port or internal buffer.
// R20 - Command acknowledge asserts once a debug command is accepted and done.
// R21 - Capture-IR loads the instruction shift register with 0001b.
//
// Purpose: Test access port reset, debug command port and support pins
// Assumes: Pins are asynchronous to ref_clk_in; all but trigger_event_in pass two flops
// Notes:   The link clock is sampled; 40 MHz covers a 200 ns test clock
`timescale 1ns/1ps
`include "trdp_defs.vh"
module trdp_port #(
    parameter SYSRST_CYC = `TRDP_SYSRST_CYC
) (
    input  wire       ref_clk_in,
    input  wire       rst_n_in,
    input  wire       tck_in,
    input  wire       tms_in,
    input  wire       tdi_in,
    input  wire       test_reset_n_in,
    input  wire       system_reset_n_in,
    input  wire       power_good_in,
    input  wire       break_or_trace_request_in,
    input  wire       debug_enter_strap_in,
    input  wire       instruction_trace_strap_in,
    input  wire       debug_disable_strap_in,
    input  wire       trigger_event_in,
    output reg        tdo_out,
    output reg        tdo_oe_out,
    output reg        command_acknowledge_out,
    output reg        stop_transmit_out,
    output reg        trigger_out,
    output reg        system_reset_n_out,
    output reg        debug_mode_out,
    output reg        trace_enable_out,
    output reg  [1:0] trace_dest_out,
    output reg        test_logic_active_out,
    output reg  [2:0] strap_latched_out
);
    // Synchronised pins; test reset and system reset are synchronised inverted
    wire [9:0] pins_s;
    trdp_sync #(.WIDTH(10)) u_sync (
        .ref_clk_in   (ref_clk_in),
        .rst_n_in     (rst_n_in),
        .async_in     ({~test_reset_n_in, ~system_reset_n_in, power_good_in,
                        break_or_trace_request_in, debug_enter_strap_in,
                        instruction_trace_strap_in, debug_disable_strap_in,
                        tck_in, tms_in, tdi_in}),
        .sync_out     (pins_s)
    );
    wire trst_s  = pins_s[9];
    wire sysrst_s = pins_s[8];
    wire pg_s    = pins_s[7];
    wire brk_s   = pins_s[6];
    wire tck_s   = pins_s[2];
    wire tms_s   = pins_s[1];
    wire tdi_s   = pins_s[0];

    // One test clock for controller and debug interface [R17] [R18]
    reg  tck_d;
    wire tck_rise = tck_s & ~tck_d;
    wire tck_fall = ~tck_s & tck_d;

    wire [3:0] tap_state;
    // Power-good is deliberately absent from the controller's reset [R1]
    trdp_tap_fsm u_fsm (
        .ref_clk_in    (ref_clk_in),
        .rst_n_in      (rst_n_in),
        .test_reset_in (trst_s),
        .tck_rise_in   (tck_rise),
        .tms_in        (tms_s),
        .state_out     (tap_state)
    );

    reg [`TRDP_IR_W-1:0] ir_shift;
    reg [`TRDP_IR_W-1:0] ir_cur;
    reg [`TRDP_DR_W-1:0] dr_shift;
    reg                  byp;
    reg                  pg_d;
    reg                  brk_d;
    reg                  cmd_pending;
    reg [`TRDP_DR_W-1:0] cmd_word;
    reg [15:0]           sysrst_cnt;

    wire in_reset = (tap_state == `TRDP_ST_RESET);
    wire dbg_sel  = (ir_cur == `TRDP_IR_DEBUG);
    wire sh_ir    = (tap_state == `TRDP_ST_SH_IR);
    wire sh_dr    = (tap_state == `TRDP_ST_SH_DR);
    wire sys_rst  = (sysrst_cnt >= SYSRST_CYC[15:0]);

    // Instruction and data paths, all on test clock edges [R9] [R10]
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tck_d    <= 1'b0;
            ir_shift <= `TRDP_IR_RESET;
            ir_cur   <= `TRDP_IR_RESET;
            dr_shift <= {`TRDP_DR_W{1'b0}};
            byp      <= 1'b0;
        end else begin
            tck_d <= tck_s;
            if (trst_s) begin
                ir_shift <= `TRDP_IR_RESET;          // [R2]
                ir_cur   <= `TRDP_IR_RESET;
                dr_shift <= {`TRDP_DR_W{1'b0}};
                byp      <= 1'b0;
            end else if (tck_rise) begin
                case (tap_state)
                    `TRDP_ST_RESET:  ir_cur   <= `TRDP_IR_RESET;  // [R6]
                    `TRDP_ST_CAP_IR: ir_shift <= `TRDP_IR_CAPTURE; // [R21]
                    `TRDP_ST_SH_IR:  ir_shift <= {tdi_s, ir_shift[`TRDP_IR_W-1:1]};
                    `TRDP_ST_CAP_DR: byp      <= 1'b0;
                    `TRDP_ST_SH_DR: begin
                        if (dbg_sel) begin
                            dr_shift <= {tdi_s, dr_shift[`TRDP_DR_W-1:1]};
                        end else begin
                            byp <= tdi_s;
                        end
                    end
                    default: ;
                endcase
            end else if (tck_fall && tap_state == `TRDP_ST_UPD_IR) begin
                ir_cur <= ir_shift;
            end
        end
    end

    // TDO changes on the falling test clock, driven only while shifting [R11]
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tdo_out    <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else if (trst_s) begin
            tdo_out    <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_out <= sh_ir | sh_dr;
            if (sh_ir) begin
                tdo_out <= ir_shift[0];
            end else if (sh_dr) begin
                tdo_out <= dbg_sel ? dr_shift[0] : byp;
            end else begin
                tdo_out <= 1'b0;
            end
        end
    end

    // Straps caught on the power-good rise only; outputs unchanged after [R7] [R8]
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pg_d              <= 1'b0;
            strap_latched_out <= 3'h0;
        end else begin
            pg_d <= pg_s;
            if (pg_s && !pg_d) begin
                strap_latched_out <= pins_s[5:3];    // [R7]
            end
        end
    end

    // System reset qualified over the minimum hold time [R12]
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sysrst_cnt         <= 16'h0000;
            system_reset_n_out <= 1'b0;
        end else begin
            if (!sysrst_s) begin
                sysrst_cnt <= 16'h0000;
            end else if (!sys_rst) begin
                sysrst_cnt <= sysrst_cnt + 16'h0001;
            end
            system_reset_n_out <= ~(sys_rst | ~pg_s);   // [R13]
        end
    end

    // Command capture at Update-DR with the debug instruction selected
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmd_pending <= 1'b0;
            cmd_word    <= {`TRDP_DR_W{1'b0}};
        end else if (trst_s || in_reset) begin
            cmd_pending <= 1'b0;                     // [R6]
        end else if (tck_fall && tap_state == `TRDP_ST_UPD_DR && dbg_sel) begin
            cmd_pending <= 1'b1;
            cmd_word    <= dr_shift;
        end else begin
            cmd_pending <= 1'b0;
        end
    end

    // Debug state; break, commands, trigger, trace routing
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            brk_d                   <= 1'b0;
            debug_mode_out          <= 1'b0;
            trace_enable_out        <= 1'b0;
            trace_dest_out          <= `TRDP_DEST_SERIAL;
            stop_transmit_out       <= 1'b0;
            command_acknowledge_out <= 1'b0;
            trigger_out             <= 1'b0;
            test_logic_active_out   <= 1'b0;
        end else begin
            brk_d                   <= brk_s;
            command_acknowledge_out <= 1'b0;
            test_logic_active_out   <= ~in_reset;     // [R6]
            trigger_out             <= trigger_event_in & ~strap_latched_out[0]; // [R16]
            if (sys_rst) begin
                debug_mode_out   <= strap_latched_out[2] & ~strap_latched_out[0];
                trace_enable_out <= strap_latched_out[1];
                trace_dest_out   <= `TRDP_DEST_SERIAL;
            end else if (!strap_latched_out[0]) begin
                // Debug entry request unless the trace strap is latched; then a trace toggle [R14]
                if (brk_s && !brk_d) begin
                    if (strap_latched_out[1]) begin
                        trace_enable_out <= ~trace_enable_out;
                    end else begin
                        debug_mode_out <= 1'b1;
                    end
                end
                if (cmd_pending) begin
                    command_acknowledge_out <= 1'b1;            // [R20]
                    case (cmd_word[3:0])
                        `TRDP_CMD_ENTER:  debug_mode_out <= 1'b1;
                        `TRDP_CMD_RESUME: debug_mode_out <= 1'b0;
                        `TRDP_CMD_TRIG:   trigger_out    <= 1'b1;
                        `TRDP_CMD_TRDEST: trace_dest_out <= cmd_word[5:4]; // [R19]
                        default: ;
                    endcase
                end
            end
            stop_transmit_out <= debug_mode_out;     // [R15]
        end
    end
endmodule // trdp_port

// >>> tb/trdp_port_checker.sv
// Purpose: Concurrent checks on the pins of the test reset and debug port
// Assumes: Bound to every trdp_port instance; sees only its ports
// Notes:   Link clock rises are found here with two flops, ahead of the block
`timescale 1ns/1ps
module trdp_port_checker #(
    parameter SYSRST_CYC = 32
) (
    input wire       ref_clk_in,
    input wire       rst_n_in,
    input wire       tck_in,
    input wire       tms_in,
    input wire       tdi_in,
    input wire       test_reset_n_in,
    input wire       system_reset_n_in,
    input wire       power_good_in,
    input wire       break_or_trace_request_in,
    input wire       debug_enter_strap_in,
    input wire       instruction_trace_strap_in,
    input wire       debug_disable_strap_in,
    input wire       trigger_event_in,
    input wire       tdo_out,
    input wire       tdo_oe_out,
    input wire       command_acknowledge_out,
    input wire       stop_transmit_out,
    input wire       trigger_out,
    input wire       system_reset_n_out,
    input wire       debug_mode_out,
    input wire       trace_enable_out,
    input wire [1:0] trace_dest_out,
    input wire       test_logic_active_out,
    input wire [2:0] strap_latched_out
);
    reg [1:0] tck_q;
    reg [2:0] hi_cnt;
    reg [5:0] low_cnt;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Saturating counts: TMS-high link rises and system reset low cycles
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tck_q   <= 2'h0;
            hi_cnt  <= 3'h0;
            low_cnt <= 6'h00;
        end else begin
            tck_q <= {tck_q[0], tck_in};
            if (tck_q == 2'h1)
                hi_cnt <= !tms_in ? 3'h0 : (hi_cnt == 3'h7 ? 3'h7 : hi_cnt + 3'h1);
            if (system_reset_n_in)
                low_cnt <= 6'h00;
            else if (low_cnt != 6'h3F)
                low_cnt <= low_cnt + 6'h01;
        end
    end
    trst_clear_a: assert property (!test_reset_n_in [*6] |-> !test_logic_active_out && !tdo_oe_out)
        else $error("test reset left the controller running");
    tms_reset_a: assert property (hi_cnt >= 3'h5 |-> ##[0:8] !test_logic_active_out)
        else $error("five high TMS rises did not reset the controller");
    ack_pulse_a: assert property (command_acknowledge_out |=> !command_acknowledge_out)
        else $error("acknowledge longer than one cycle");
    stop_follow_a: assert property ($rose(debug_mode_out) |=> stop_transmit_out)
        else $error("stop output not raised on debug entry");
    strap_hold_a: assert property (power_good_in [*8] |=> $stable(strap_latched_out))
        else $error("straps changed while power good held");
    pg_reset_a: assert property (!power_good_in [*6] |-> !system_reset_n_out)
        else $error("power good low did not hold system reset");
    sysrst_len_a: assert property (low_cnt >= SYSRST_CYC + 8 |-> !system_reset_n_out)
        else $error("long system reset request not honoured");
    trig_follow_a: assert property (trigger_event_in && !strap_latched_out[0] |=> trigger_out)
        else $error("trigger event not passed to output");
    pg_no_tap_a: assert property ($fell(power_good_in) && test_logic_active_out && test_reset_n_in
                                  |=> test_logic_active_out [*4])
        else $error("power good drop reset the controller");
    cover property ($rose(debug_mode_out));
    cover property (command_acknowledge_out);
    cover property ($fell(system_reset_n_out));
endmodule // trdp_port_checker

bind trdp_port trdp_port_checker #(.SYSRST_CYC(SYSRST_CYC)) i_chk (.*);

// >>> tb/trdp_host_model.sv
// Purpose: External debug unit driving the link and system reset pins
// Assumes: Tasks are started at a reference clock falling edge
// Notes:   Link clock stands low between frames; released lines float high
`timescale 1ns/1ps
module trdp_host_model (
    input  wire tdo_in,
    input  wire tdo_oe_in,
    output reg  tck_out,
    output reg  tms_out,
    output reg  tdi_out,
    output reg  system_reset_n_out
);
    wire tdo_line = tdo_oe_in ? tdo_in : 1'b1; // Pull-up holds it when undriven
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
        system_reset_n_out = 1'b1;
    end
    // One 200 ns link clock; only the four test pins are needed
    task tick(input logic m, input logic d, output logic q);
        tms_out = m;
        tdi_out = d;
        #100 tck_out = 1'b1;
        q = tdo_line;
        #100 tck_out = 1'b0;
    endtask
    // From idle, scan n bits LSB first and return to idle
    task scan(input logic ir, input int n, input logic [7:0] v, output logic [7:0] q);
        logic b;
        int   i;
        q = 8'h00;
        tick(1'b1, 1'b1, b);
        if (ir)
            tick(1'b1, 1'b1, b);
        tick(1'b0, 1'b1, b);
        tick(1'b0, 1'b1, b);
        for (i = 0; i < n; i++) begin
            tick(i == n - 1, v[i], b);
            q[i] = b;
        end
        tick(1'b1, 1'b1, b);
        tick(1'b0, 1'b1, b);
    endtask
    // A real request lasts at least four link periods; shorter only on purpose
    task sys_reset(input int ns);
        system_reset_n_out = 1'b0;
        #(ns) system_reset_n_out = 1'b1;
    endtask
endmodule // trdp_host_model

// >>> tb/tb_trdp_port.sv
// Purpose: Self-checking bench for the test reset and debug port
// Assumes: The host model owns the link pins and the system reset request
// Notes:   Rows are {command, debug mode, trace destination}
`timescale 1ns/1ps
module tb_trdp_port;
    reg         ref_clk_in = 1'b0;
    reg         rst_n_in = 1'b0;
    reg         test_reset_n_in = 1'b1;
    reg         power_good_in = 1'b0;
    reg         brk = 1'b0;
    reg   [2:0] straps = 3'h2;
    reg         trig_ev = 1'b0;
    wire        tck, tms, tdi, sys_n, tdo, tdo_oe, ack, stop, trig, sys_out, dm, te, act;
    wire  [1:0] dest;
    wire  [2:0] strap_q;
    int         failures = 0;
    int         compares = 0;
    int         ack_cnt = 0;
    int         trig_cnt = 0;
    int         fall_cnt = 0;
    logic       trig_q = 1'b0;
    logic       sys_q = 1'b0;
    logic [7:0] q;
    logic [10:0] rows [5] = '{11'h00C, 11'h0A5, 11'h126, 11'h012, 11'h020};

    always #12.5 ref_clk_in = ~ref_clk_in;

    trdp_host_model i_host (.tdo_in(tdo), .tdo_oe_in(tdo_oe), .tck_out(tck), .tms_out(tms),
                            .tdi_out(tdi), .system_reset_n_out(sys_n));
    trdp_port i_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .test_reset_n_in(test_reset_n_in), .system_reset_n_in(sys_n),
        .power_good_in(power_good_in), .break_or_trace_request_in(brk),
        .debug_enter_strap_in(straps[2]), .instruction_trace_strap_in(straps[1]),
        .debug_disable_strap_in(straps[0]), .trigger_event_in(trig_ev), .tdo_out(tdo),
        .tdo_oe_out(tdo_oe), .command_acknowledge_out(ack), .stop_transmit_out(stop),
        .trigger_out(trig), .system_reset_n_out(sys_out), .debug_mode_out(dm),
        .trace_enable_out(te), .trace_dest_out(dest), .test_logic_active_out(act),
        .strap_latched_out(strap_q));

    always @(negedge ref_clk_in) begin
        if (ack === 1'b1) ack_cnt++;
        if (trig === 1'b1 && trig_q !== 1'b1) trig_cnt++;
        if (sys_out === 1'b0 && sys_q === 1'b1) fall_cnt++;
        trig_q <= trig;
        sys_q <= sys_out;
    end

    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task finish_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task wait_clk(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    task pulse_break;
        brk = 1'b1;
        wait_clk(4);
        brk = 1'b0;
        wait_clk(6);
    endtask

    // Whole run is near 36 us; over five times that means a hang
    initial begin
        #200000;
        failures++;
        finish_test;
    end

    initial begin
        int   i;
        int   a;
        logic t;
        wait_clk(20);
        check("sys out in reset", sys_out, 1'b0);
        check("active in reset", act, 1'b0);
        rst_n_in = 1'b1;
        wait_clk(5);
        power_good_in = 1'b1;
        wait_clk(10);
        check("straps", strap_q, 3'h2);
        straps = 3'h5;
        wait_clk(10);
        check("straps held", strap_q, 3'h2);
        check("sys out", sys_out, 1'b1);
        straps = 3'h0;
        $display("test straps done");
        i_host.tick(1'b0, 1'b1, t);
        wait_clk(8);
        check("active idle", act, 1'b1);
        check("tdo idle", tdo_oe, 1'b0);
        i_host.tick(1'b1, 1'b1, t);
        i_host.tick(1'b1, 1'b1, t);
        wait_clk(8);
        check("two high", act, 1'b1);
        i_host.tick(1'b1, 1'b1, t);
        wait_clk(8);
        check("three high", act, 1'b0);
        i_host.tick(1'b0, 1'b1, t);
        repeat (6) i_host.tick(1'b1, 1'b1, t);
        wait_clk(8);
        check("six high", act, 1'b0);
        i_host.tick(1'b0, 1'b1, t);
        $display("test tms reset done");
        i_host.scan(1'b1, 4, 8'h08, q);
        check("ir capture", q[3:0], 4'h1);
        for (i = 0; i < 5; i++) begin
            a = ack_cnt;
            i_host.scan(1'b0, 8, rows[i][10:3], q);
            wait_clk(4);
            check("debug mode", dm, rows[i][2]);
            check("stop", stop, rows[i][2]);
            check("trace dest", dest, rows[i][1:0]);
            check("acks", 8'(ack_cnt - a), 8'h01);
        end
        a = trig_cnt;
        i_host.scan(1'b0, 8, 8'h03, q);
        trig_ev = 1'b1;
        wait_clk(3);
        trig_ev = 1'b0;
        wait_clk(4);
        check("trigger pulses", 8'(trig_cnt - a), 8'h02);
        $display("test commands done");
        t = te;
        pulse_break;
        check("trace toggle", te, !t);
        check("no entry", dm, 1'b0);
        power_good_in = 1'b0;
        wait_clk(10);
        check("tap kept", act, 1'b1);
        power_good_in = 1'b1;
        wait_clk(10);
        check("straps new", strap_q, 3'h0);
        pulse_break;
        check("break entry", dm, 1'b1);
        check("stop entry", stop, 1'b1);
        $display("test break done");
        a = fall_cnt;
        i_host.sys_reset(250);
        wait_clk(10);
        check("short reset", 8'(fall_cnt - a), 8'h00);
        i_host.sys_reset(1000);
        wait_clk(10);
        check("full reset", 8'(fall_cnt - a), 8'h01);
        check("sys out back", sys_out, 1'b1);
        check("debug cleared", dm, 1'b0);
        $display("test system reset done");
        test_reset_n_in = 1'b0;
        wait_clk(8);
        check("trst active", act, 1'b0);
        test_reset_n_in = 1'b1;
        wait_clk(4);
        i_host.tick(1'b0, 1'b1, t);
        i_host.scan(1'b0, 8, 8'h01, q);
        wait_clk(4);
        check("ir cleared", dm, 1'b0);
        $display("test test reset done");
        straps = 3'h5;
        power_good_in = 1'b0;
        wait_clk(10);
        power_good_in = 1'b1;
        wait_clk(10);
        check("straps off", strap_q, 3'h5);
        a = ack_cnt;
        i_host.scan(1'b1, 4, 8'h08, q);
        i_host.scan(1'b0, 8, 8'h01, q);
        trig_ev = 1'b1;
        wait_clk(4);
        check("refused acks", 8'(ack_cnt - a), 8'h00);
        check("refused entry", dm, 1'b0);
        check("refused trigger", trig, 1'b0);
        trig_ev = 1'b0;
        straps = 3'h4;
        power_good_in = 1'b0;
        wait_clk(10);
        power_good_in = 1'b1;
        wait_clk(10);
        i_host.sys_reset(1000);
        wait_clk(10);
        check("strap entry", dm, 1'b1);
        check("strap stop", stop, 1'b1);
        $display("test latched straps done");
        finish_test;
    end
endmodule // tb_trdp_port
